// file: asr_rx_status.sv
`timescale 1ns/1ps
module asr_rx_status #(
  parameter int unsigned RX_DEPTH = asr_pkg::RX_DEPTH_DOC
) (
  input  wire logic                        CLK_I,
  input  wire logic                        SYS_RST_I,
  // processor i/o port
  input  wire logic [asr_pkg::ADDR_W-1:0]  IO_ADDR_I,
  input  wire logic [asr_pkg::DATA_W-1:0]  IO_WDATA_I,
  input  wire logic                        IO_WR_I,
  input  wire logic                        IO_RD_I,
  output logic      [asr_pkg::DATA_W-1:0]  IO_RDATA_O,
  // receive shifter handoff
  input  wire logic                        RX_BYTE_VALID_I,
  input  wire logic [asr_pkg::DATA_W-1:0]  RX_BYTE_I,
  input  wire logic                        RX_PARITY_BAD_I,
  input  wire logic                        RX_STOP_BIT_I,
  output logic                             RX_SHIFT_READY_O,
  output logic                             RX_RESET_O,
  // control bits held elsewhere
  input  wire logic                        PARITY_ENABLE_SEL_I,
  input  wire logic                        ERR_FLAG_CLEAR_I,
  input  wire logic                        IO_HALT_MODE_I,
  // modem pins
  input  wire logic                        CARRIER_DETECT_I,
  input  wire logic                        CLEAR_TO_SEND_I,
  // transmit shifter handoff
  input  wire logic                        TX_SHIFT_LOAD_I,
  output logic                             TX_HOLD_FULL_O,
  // interrupt requests
  output logic                             RX_IRQ_O,
  output logic                             TX_IRQ_O
);
  import asr_pkg::*;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] target);
    addr_hit = (addr == target);
  endfunction

  // modem pin synchronisers
  logic [1:0] pins_s;
  logic       carrier_s;
  logic       cts_s;

  asr_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_i (CLK_I),
    .rst_i (SYS_RST_I),
    .d_i   ({CARRIER_DETECT_I, CLEAR_TO_SEND_I}),
    .q_o   (pins_s)
  );

  assign carrier_s = pins_s[1];
  assign cts_s     = pins_s[0];

  // register access decode
  logic stat_rd;
  logic stat_wr;
  logic hold0_rd;
  logic hold0_wr;
  logic hold1_wr;
  logic tx_hold_wr;

  always_comb begin
    stat_rd    = IO_RD_I && addr_hit(IO_ADDR_I, LINE_STATUS_0_ADDR);
    stat_wr    = IO_WR_I && addr_hit(IO_ADDR_I, LINE_STATUS_0_ADDR);
    hold0_rd   = IO_RD_I && addr_hit(IO_ADDR_I, RX_HOLDING_0_ADDR);
    hold0_wr   = IO_WR_I && addr_hit(IO_ADDR_I, RX_HOLDING_0_ADDR);
    hold1_wr   = IO_WR_I && addr_hit(IO_ADDR_I, RX_HOLDING_1_ADDR);
    tx_hold_wr = IO_WR_I && addr_hit(IO_ADDR_I, TX_HOLDING_0_ADDR);
  end

  // receive buffering
  asr_fifo_if #(.WIDTH(DATA_W)) rx_q ();

  logic carrier_r;
  logic rx_flush;

  // carrier high or io halt empties the buffer and drops rx_full_flag
  assign rx_flush = carrier_s || IO_HALT_MODE_I;

  asr_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .flush_i (rx_flush),
    .port    (rx_q.fifo)
  );

  // the buffer head is the holding register; its valid is rx_full_flag
  logic rx_full_flag;
  assign rx_full_flag = rx_q.out_valid;
  assign rx_q.out_ready = hold0_rd;

  // shifter handoff: one stalled byte may wait for room
  asr_rx_state_t            rx_state_r;
  asr_rx_state_t            rx_state_nxt;
  logic [DATA_W-1:0]        pend_data_r;
  logic [DATA_W-1:0]        pend_data_nxt;
  logic                     rx_shift_ready_r;
  logic                     rx_shift_ready_nxt;
  logic                     rx_take;
  logic                     overrun_set;

  // no byte is taken while the receiver is held in reset or halted
  assign rx_take = RX_BYTE_VALID_I && !carrier_r && !IO_HALT_MODE_I;
  // a byte that finds no room in the holding stage is an overrun
  assign overrun_set = rx_take && !rx_q.in_ready;

  always_comb begin
    rx_state_nxt  = rx_state_r;
    pend_data_nxt = pend_data_r;
    rx_q.in_valid = 1'b0;
    rx_q.in_data  = RX_BYTE_I;
    unique case (rx_state_r)
      RX_ACCEPT: begin
        if (rx_take) begin
          // errored bytes are loaded just like good ones
          rx_q.in_valid = 1'b1;
          if (!rx_q.in_ready) begin
            rx_state_nxt  = RX_STALLED;
            pend_data_nxt = RX_BYTE_I;
          end
        end
      end
      RX_STALLED: begin
        rx_q.in_valid = 1'b1;
        rx_q.in_data  = pend_data_r;
        if (rx_take) begin
          // the newer byte overwrites the one still waiting
          pend_data_nxt = RX_BYTE_I;
        end else if (rx_q.in_ready) begin
          rx_state_nxt = RX_ACCEPT;
        end
      end
    endcase
    if (SYS_RST_I || rx_flush || carrier_r) begin
      rx_state_nxt  = RX_ACCEPT;
      pend_data_nxt = HOLDING_RST;
    end
    rx_shift_ready_nxt = (rx_state_nxt == RX_ACCEPT);
  end

  always_ff @(posedge CLK_I) begin
    rx_state_r       <= rx_state_nxt;
    pend_data_r      <= pend_data_nxt;
    rx_shift_ready_r <= rx_shift_ready_nxt;
  end

  // error flags
  logic overrun_flag_r;
  logic overrun_flag_nxt;
  logic parity_err_flag_r;
  logic parity_err_flag_nxt;
  logic framing_err_flag_r;
  logic framing_err_flag_nxt;
  logic parity_set;
  logic framing_set;
  logic err_zap;

  assign parity_set  = rx_take && PARITY_ENABLE_SEL_I &&
                       RX_PARITY_BAD_I;
  assign framing_set = rx_take && !RX_STOP_BIT_I;
  assign err_zap     = SYS_RST_I || carrier_s || IO_HALT_MODE_I;

  // a set in the same cycle as a software clear wins
  always_comb begin
    overrun_flag_nxt     = overrun_set ||
                           (overrun_flag_r && !ERR_FLAG_CLEAR_I);
    parity_err_flag_nxt  = parity_set ||
                           (parity_err_flag_r && !ERR_FLAG_CLEAR_I);
    framing_err_flag_nxt = framing_set ||
                           (framing_err_flag_r && !ERR_FLAG_CLEAR_I);
    if (err_zap) begin
      overrun_flag_nxt     = 1'b0;
      parity_err_flag_nxt  = 1'b0;
      framing_err_flag_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    overrun_flag_r     <= overrun_flag_nxt;
    parity_err_flag_r  <= parity_err_flag_nxt;
    framing_err_flag_r <= framing_err_flag_nxt;
  end

  // carrier detect status and its rising-edge event
  logic carrier_nxt;
  logic carrier_seen_r;
  logic carrier_seen_nxt;
  logic carrier_rise_r;
  logic carrier_rise_nxt;

  always_comb begin
    // input high wins over the read that would clear the bit
    carrier_nxt      = carrier_s || (carrier_r && !stat_rd);
    carrier_seen_nxt = carrier_s;
    // the edge is kept until software looks at the status register
    carrier_rise_nxt = (carrier_s && !carrier_seen_r) ||
                       (carrier_rise_r && !stat_rd);
    if (SYS_RST_I) begin
      carrier_nxt      = 1'b0;
      carrier_seen_nxt = 1'b0;
      carrier_rise_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    carrier_r      <= carrier_nxt;
    carrier_seen_r <= carrier_seen_nxt;
    carrier_rise_r <= carrier_rise_nxt;
  end

  // transmit empty flag
  logic tx_empty_flag_r;
  logic tx_empty_flag_nxt;
  logic tx_hold_full_r;
  logic tx_hold_full_nxt;
  logic tx_empty_view;

  always_comb begin
    tx_empty_flag_nxt = tx_empty_flag_r;
    if (tx_hold_wr) tx_empty_flag_nxt = 1'b0;
    // the shifter load is the hardware set and wins over the write
    if (TX_SHIFT_LOAD_I) tx_empty_flag_nxt = 1'b1;
    if (SYS_RST_I || IO_HALT_MODE_I) begin
      tx_empty_flag_nxt = TX_EMPTY_RST;
    end
    tx_hold_full_nxt = !tx_empty_flag_nxt;
  end

  always_ff @(posedge CLK_I) begin
    tx_empty_flag_r <= tx_empty_flag_nxt;
    tx_hold_full_r  <= tx_hold_full_nxt;
  end

  // clear-to-send only masks the flag seen by software and interrupts
  assign tx_empty_view = tx_empty_flag_r && !cts_s;

  // enables and software-written holding values
  logic              rx_irq_en_r;
  logic              rx_irq_en_nxt;
  logic              tx_irq_en_r;
  logic              tx_irq_en_nxt;
  logic [DATA_W-1:0] sw_hold0_r;
  logic [DATA_W-1:0] sw_hold0_nxt;
  logic [DATA_W-1:0] hold1_r;
  logic [DATA_W-1:0] hold1_nxt;

  always_comb begin
    rx_irq_en_nxt = rx_irq_en_r;
    tx_irq_en_nxt = tx_irq_en_r;
    sw_hold0_nxt  = sw_hold0_r;
    hold1_nxt     = hold1_r;
    if (stat_wr) begin
      rx_irq_en_nxt = IO_WDATA_I[RX_IRQ_EN_BIT];
      tx_irq_en_nxt = IO_WDATA_I[TX_IRQ_EN_BIT];
    end
    // only lands while nothing received is waiting to be read
    if (hold0_wr && !rx_full_flag) sw_hold0_nxt = IO_WDATA_I;
    if (hold1_wr) hold1_nxt = IO_WDATA_I;
    if (SYS_RST_I) begin
      rx_irq_en_nxt = STATUS_RST[RX_IRQ_EN_BIT];
      tx_irq_en_nxt = STATUS_RST[TX_IRQ_EN_BIT];
      sw_hold0_nxt  = HOLDING_RST;
      hold1_nxt     = HOLDING_RST;
    end
  end

  always_ff @(posedge CLK_I) begin
    rx_irq_en_r <= rx_irq_en_nxt;
    tx_irq_en_r <= tx_irq_en_nxt;
    sw_hold0_r  <= sw_hold0_nxt;
    hold1_r     <= hold1_nxt;
  end

  // read data and interrupt requests
  logic [DATA_W-1:0] status_view;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              rx_irq_r;
  logic              rx_irq_nxt;
  logic              tx_irq_r;
  logic              tx_irq_nxt;

  always_comb begin
    status_view                = STATUS_RST;
    status_view[RX_FULL_BIT]   = rx_full_flag;
    status_view[OVERRUN_BIT]   = overrun_flag_r;
    status_view[PARITY_BIT]    = parity_err_flag_r;
    status_view[FRAMING_BIT]   = framing_err_flag_r;
    status_view[RX_IRQ_EN_BIT] = rx_irq_en_r;
    status_view[CARRIER_BIT]   = carrier_r;
    status_view[TX_EMPTY_BIT]  = tx_empty_view;
    status_view[TX_IRQ_EN_BIT] = tx_irq_en_r;
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (stat_rd) rdata_nxt = status_view;
    if (hold0_rd) begin
      rdata_nxt = rx_full_flag ? rx_q.out_data : sw_hold0_r;
    end
    if (IO_RD_I && addr_hit(IO_ADDR_I, RX_HOLDING_1_ADDR)) begin
      rdata_nxt = hold1_r;
    end
    // the irq lags its cause by one clock so the pin comes from a flop
    rx_irq_nxt = rx_irq_en_r && (rx_full_flag || overrun_flag_r ||
                 parity_err_flag_r || framing_err_flag_r ||
                 carrier_rise_r);
    tx_irq_nxt = tx_irq_en_r && tx_empty_view;
    if (SYS_RST_I) begin
      rdata_nxt  = HOLDING_RST;
      rx_irq_nxt = 1'b0;
      tx_irq_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    rdata_r  <= rdata_nxt;
    rx_irq_r <= rx_irq_nxt;
    tx_irq_r <= tx_irq_nxt;
  end

  assign IO_RDATA_O       = rdata_r;
  assign RX_SHIFT_READY_O = rx_shift_ready_r;
  assign RX_RESET_O       = carrier_r;
  assign TX_HOLD_FULL_O   = tx_hold_full_r;
  assign RX_IRQ_O         = rx_irq_r;
  assign TX_IRQ_O         = tx_irq_r;

endmodule

// file: asr_pkg.sv
package asr_pkg;

  localparam int unsigned DATA_W         = 8;
  localparam int unsigned ADDR_W         = 8;

  // i/o addresses of the registers this block answers
  localparam logic [7:0]  LINE_STATUS_0_ADDR = 8'h04;
  localparam logic [7:0]  TX_HOLDING_0_ADDR  = 8'h06;
  localparam logic [7:0]  RX_HOLDING_0_ADDR  = 8'h08;
  localparam logic [7:0]  RX_HOLDING_1_ADDR  = 8'h09;

  // line_status_0 field positions
  localparam int unsigned RX_FULL_BIT    = 7;
  localparam int unsigned OVERRUN_BIT    = 6;
  localparam int unsigned PARITY_BIT     = 5;
  localparam int unsigned FRAMING_BIT    = 4;
  localparam int unsigned RX_IRQ_EN_BIT  = 3;
  localparam int unsigned CARRIER_BIT    = 2;
  localparam int unsigned TX_EMPTY_BIT   = 1;
  localparam int unsigned TX_IRQ_EN_BIT  = 0;

  // reset values
  localparam logic [7:0]  STATUS_RST     = 8'h00;
  localparam logic [7:0]  HOLDING_RST    = 8'h00;
  localparam logic        TX_EMPTY_RST   = 1'b1;
  localparam logic        SYNC_RST       = 1'b0;

  // receive buffering depths
  localparam int unsigned RX_DEPTH_DOC   = 4;
  localparam int unsigned FIFO_DEPTH_DEF = 16;

  typedef enum logic [0:0] {
    RX_ACCEPT  = 1'b0,
    RX_STALLED = 1'b1
  } asr_rx_state_t;

endpackage

// file: asr_fifo_if.sv
`timescale 1ns/1ps
interface asr_fifo_if #(
  parameter int unsigned WIDTH = 8
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface

// file: asr_sync.sv
`timescale 1ns/1ps
module asr_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  import asr_pkg::*;

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_nxt;

  always_comb begin
    meta_nxt = rst_i ? {WIDTH{SYNC_RST}} : d_i;
    q_nxt    = rst_i ? {WIDTH{SYNC_RST}} : meta_r;
  end

  always_ff @(posedge clk_i) begin
    meta_r <= meta_nxt;
    q_o    <= q_nxt;
  end
endmodule

// file: asr_fifo.sv
`timescale 1ns/1ps
module asr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic flush_i,
  asr_fifo_if.fifo  port
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] wr_ptr_nxt;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [PTR_W-1:0] rd_ptr_nxt;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             push;
  logic             pop;

  assign port.in_ready  = (count_r != FULL);
  assign port.out_valid = (count_r != '0);
  assign port.out_data  = mem[rd_ptr_r];
  assign push = port.in_valid && port.in_ready;
  assign pop  = port.out_ready && port.out_valid;

  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    if (push) wr_ptr_nxt = (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
    if (pop)  rd_ptr_nxt = (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
    if (push && !pop) count_nxt = count_r + 1'b1;
    if (pop && !push) count_nxt = count_r - 1'b1;
    if (rst_i || flush_i) begin
      wr_ptr_nxt = '0;
      rd_ptr_nxt = '0;
      count_nxt  = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    wr_ptr_r <= wr_ptr_nxt;
    rd_ptr_r <= rd_ptr_nxt;
    count_r  <= count_nxt;
    if (push) begin
      mem[wr_ptr_r] <= port.in_data;
    end
  end
endmodule

// file: asr_rx_status_sva.sv
`timescale 1ns/1ps
module asr_rx_status_sva
  import asr_pkg::*;
#(
  parameter int unsigned RX_DEPTH = RX_DEPTH_DOC
) (
  input wire logic              CLK_I,
  input wire logic              SYS_RST_I,
  input wire logic [ADDR_W-1:0] IO_ADDR_I,
  input wire logic [DATA_W-1:0] IO_WDATA_I,
  input wire logic              IO_WR_I,
  input wire logic              IO_RD_I,
  input wire logic [DATA_W-1:0] IO_RDATA_O,
  input wire logic              RX_BYTE_VALID_I,
  input wire logic [DATA_W-1:0] RX_BYTE_I,
  input wire logic              RX_PARITY_BAD_I,
  input wire logic              RX_STOP_BIT_I,
  input wire logic              RX_SHIFT_READY_O,
  input wire logic              RX_RESET_O,
  input wire logic              PARITY_ENABLE_SEL_I,
  input wire logic              ERR_FLAG_CLEAR_I,
  input wire logic              IO_HALT_MODE_I,
  input wire logic              CARRIER_DETECT_I,
  input wire logic              CLEAR_TO_SEND_I,
  input wire logic              TX_SHIFT_LOAD_I,
  input wire logic              TX_HOLD_FULL_O,
  input wire logic              RX_IRQ_O,
  input wire logic              TX_IRQ_O
);
  logic tx_en_r, tx_en_nxt, rx_en_r, rx_en_nxt, st_wr, st_rd, tx_wr;
  assign st_wr = IO_WR_I && IO_ADDR_I == LINE_STATUS_0_ADDR;
  assign st_rd = IO_RD_I && IO_ADDR_I == LINE_STATUS_0_ADDR;
  assign tx_wr = IO_WR_I && IO_ADDR_I == TX_HOLDING_0_ADDR;
  // shadow copies of the two enables, so irq outputs can be judged
  always_comb begin
    tx_en_nxt = st_wr ? IO_WDATA_I[TX_IRQ_EN_BIT] : tx_en_r;
    rx_en_nxt = st_wr ? IO_WDATA_I[RX_IRQ_EN_BIT] : rx_en_r;
  end
  always_ff @(posedge CLK_I) begin
    tx_en_r <= SYS_RST_I ? 1'b0 : tx_en_nxt;
    rx_en_r <= SYS_RST_I ? 1'b0 : rx_en_nxt;
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  chk_reset_outputs: assert property ($fell(SYS_RST_I) |->
    IO_RDATA_O == 8'h00 && !RX_IRQ_O && !TX_IRQ_O && !RX_RESET_O)
    else $error("outputs not at reset values");
  chk_tx_write_full: assert property (tx_wr && !TX_SHIFT_LOAD_I &&
    !IO_HALT_MODE_I |=> TX_HOLD_FULL_O)
    else $error("tx holding write did not fill");
  chk_tx_load_empty: assert property (TX_SHIFT_LOAD_I |=>
    !TX_HOLD_FULL_O) else $error("tx load did not empty holding");
  chk_halt_tx_empty: assert property (IO_HALT_MODE_I |=>
    !TX_HOLD_FULL_O) else $error("halt did not force tx empty");
  chk_carrier_resets_rx: assert property ($rose(CARRIER_DETECT_I)
    |-> ##[1:5] RX_RESET_O) else $error("carrier did not reset receiver");
  chk_rx_reset_holds: assert property (RX_RESET_O && !st_rd |=>
    RX_RESET_O) else $error("carrier bit cleared without status read");
  chk_rx_inhibit: assert property (RX_RESET_O && RX_BYTE_VALID_I &&
    RX_SHIFT_READY_O |=> RX_SHIFT_READY_O)
    else $error("byte taken while receiver in reset");
  chk_tx_irq_masked: assert property (!tx_en_r |=> !TX_IRQ_O)
    else $error("tx irq without enable");
  chk_rx_irq_masked: assert property (!rx_en_r |=> !RX_IRQ_O)
    else $error("rx irq without enable");
  chk_rdata_stands: assert property (!IO_RD_I |=> $stable(IO_RDATA_O))
    else $error("read data changed without read");
  cov_overrun_stall: cover property ($fell(RX_SHIFT_READY_O));
  cov_carrier_cycle: cover property ($fell(RX_RESET_O));
  cov_tx_irq: cover property ($rose(TX_IRQ_O));
endmodule

bind asr_rx_status asr_rx_status_sva #(.RX_DEPTH(RX_DEPTH)) u_chk (.*);

// file: asr_remote.sv
`timescale 1ns/1ps
module asr_remote (
  input  wire logic       clk_i,
  output logic            valid_o,
  output logic [7:0]      byte_o,
  output logic            par_bad_o,
  output logic            stop_o,
  output logic            carrier_o,
  output logic            cts_o,
  output logic            tx_load_o
);
  initial begin
    {valid_o, par_bad_o, tx_load_o, carrier_o, cts_o} = 5'h00;
    byte_o = 8'h00;
    stop_o = 1'b1;
  end
  // a frame arrives after gap idle cycles; released lines show inverse
  task automatic send(input logic [7:0] d, input logic pb, input logic st,
                      input int gap);
    repeat (gap) @(negedge clk_i);
    @(negedge clk_i);
    {valid_o, byte_o, par_bad_o, stop_o} = {1'b1, d, pb, st};
    @(negedge clk_i);
    {valid_o, byte_o, par_bad_o, stop_o} = {1'b0, ~d, ~pb, ~st};
  endtask
  task automatic load();
    @(negedge clk_i);
    tx_load_o = 1'b1;
    @(negedge clk_i);
    tx_load_o = 1'b0;
  endtask
  task automatic modem(input logic c, input logic t);
    @(negedge clk_i);
    carrier_o = c;
    cts_o = t;
  endtask
endmodule

// file: async_serial_rx_status_tb.sv
`timescale 1ns/1ps
module async_serial_rx_status_tb;
  import asr_pkg::*;
  `define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pen = 1'b0;
  logic efc = 1'b0, halt = 1'b0, vld, pb, stp, cd, cts, ld, rdy, rres;
  logic full, rirq, tirq;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdat, rb;
  int fails = 0, tests_run = 0, cycles = 0;
  always #4 clk = ~clk;
  asr_remote u_rem (.clk_i(clk), .valid_o(vld), .byte_o(rb), .par_bad_o(pb),
    .stop_o(stp), .carrier_o(cd), .cts_o(cts), .tx_load_o(ld));
  asr_rx_status DUT (.CLK_I(clk), .SYS_RST_I(rst), .IO_ADDR_I(addr),
    .IO_WDATA_I(wd), .IO_WR_I(wr), .IO_RD_I(rd), .IO_RDATA_O(rdat),
    .RX_BYTE_VALID_I(vld), .RX_BYTE_I(rb), .RX_PARITY_BAD_I(pb),
    .RX_STOP_BIT_I(stp), .RX_SHIFT_READY_O(rdy), .RX_RESET_O(rres),
    .PARITY_ENABLE_SEL_I(pen), .ERR_FLAG_CLEAR_I(efc),
    .IO_HALT_MODE_I(halt), .CARRIER_DETECT_I(cd), .CLEAR_TO_SEND_I(cts),
    .TX_SHIFT_LOAD_I(ld), .TX_HOLD_FULL_O(full), .RX_IRQ_O(rirq),
    .TX_IRQ_O(tirq));
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr, addr, wd} = {1'b1, a, d};
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    {rd, addr} = {1'b1, a};
    @(negedge clk);
    rd = 1'b0;
    `CHK("read data", e, rdat)
  endtask
  task automatic do_reset();
    rst = 1'b1;
    idle(4);
    rst = 1'b0;
  endtask
  task automatic t_reset();
    rdc(LINE_STATUS_0_ADDR, 8'h02);
    rdc(RX_HOLDING_0_ADDR, 8'h00);
    rdc(RX_HOLDING_1_ADDR, 8'h00);
    `CHK("tx irq", 1'b0, tirq)
  endtask
  task automatic t_fill();
    wrr(LINE_STATUS_0_ADDR, 8'h08);
    for (int i = 1; i <= 4; i++) u_rem.send(8'(i * 17), 1'b0, 1'b1, i % 2);
    idle(2);
    `CHK("shift ready", 1'b1, rdy)
    `CHK("rx irq", 1'b1, rirq)
    rdc(LINE_STATUS_0_ADDR, 8'h8a);
    u_rem.send(8'h55, 1'b0, 1'b1, 0);
    idle(1);
    `CHK("shift ready", 1'b0, rdy)
    rdc(LINE_STATUS_0_ADDR, 8'hca);
    for (int i = 1; i <= 4; i++) rdc(RX_HOLDING_0_ADDR, 8'(i * 17));
    rdc(RX_HOLDING_0_ADDR, 8'h55);
    rdc(LINE_STATUS_0_ADDR, 8'h4a);
    @(negedge clk) efc = 1'b1;
    @(negedge clk) efc = 1'b0;
    idle(2);
    `CHK("rx irq", 1'b0, rirq)
    rdc(LINE_STATUS_0_ADDR, 8'h0a);
  endtask
  task automatic t_errors();
    u_rem.send(8'ha5, 1'b1, 1'b1, 0);
    idle(1);
    rdc(LINE_STATUS_0_ADDR, 8'h8a);
    pen = 1'b1;
    u_rem.send(8'h5a, 1'b1, 1'b1, 0);
    idle(1);
    rdc(LINE_STATUS_0_ADDR, 8'haa);
    u_rem.send(8'h3c, 1'b0, 1'b0, 0);
    idle(1);
    rdc(LINE_STATUS_0_ADDR, 8'hba);
    rdc(RX_HOLDING_0_ADDR, 8'ha5);
    rdc(RX_HOLDING_0_ADDR, 8'h5a);
    wrr(TX_HOLDING_0_ADDR, 8'h11);
    @(negedge clk) halt = 1'b1;
    idle(2);
    `CHK("tx hold full", 1'b0, full)
    halt = 1'b0;
    idle(2);
    rdc(LINE_STATUS_0_ADDR, 8'h0a);
    `CHK("rx irq", 1'b0, rirq)
  endtask
  task automatic t_holding();
    wrr(RX_HOLDING_0_ADDR, 8'h6b);
    rdc(RX_HOLDING_0_ADDR, 8'h6b);
    wrr(RX_HOLDING_1_ADDR, 8'h9c);
    rdc(RX_HOLDING_1_ADDR, 8'h9c);
    wrr(8'h0f, 8'hff);
    rdc(8'h0f, 8'h9c);
  endtask
  task automatic t_carrier();
    u_rem.send(8'h77, 1'b0, 1'b1, 0);
    u_rem.modem(1'b1, 1'b0);
    idle(6);
    `CHK("rx reset", 1'b1, rres)
    `CHK("rx irq", 1'b1, rirq)
    rdc(LINE_STATUS_0_ADDR, 8'h0e);
    u_rem.modem(1'b0, 1'b0);
    idle(6);
    `CHK("rx reset", 1'b1, rres)
    // pin is low again, only the status bit keeps the receiver off
    u_rem.send(8'h33, 1'b0, 1'b0, 2);
    idle(1);
    rdc(LINE_STATUS_0_ADDR, 8'h0e);
    rdc(LINE_STATUS_0_ADDR, 8'h0a);
    rdc(RX_HOLDING_0_ADDR, 8'h6b);
    idle(1);
    `CHK("rx irq", 1'b0, rirq)
  endtask
  task automatic t_tx();
    wrr(LINE_STATUS_0_ADDR, 8'h09);
    idle(2);
    `CHK("tx irq", 1'b1, tirq)
    wrr(TX_HOLDING_0_ADDR, 8'h42);
    idle(1);
    `CHK("tx hold full", 1'b1, full)
    `CHK("tx irq", 1'b0, tirq)
    rdc(LINE_STATUS_0_ADDR, 8'h09);
    u_rem.load();
    idle(2);
    `CHK("tx irq", 1'b1, tirq)
    u_rem.modem(1'b0, 1'b1);
    idle(4);
    rdc(LINE_STATUS_0_ADDR, 8'h09);
    `CHK("tx irq", 1'b0, tirq)
    u_rem.modem(1'b0, 1'b0);
    do_reset();
    rdc(LINE_STATUS_0_ADDR, 8'h02);
  endtask
  task automatic conclude();
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    do_reset();
    t_reset();
    t_fill();
    t_errors();
    t_holding();
    t_carrier();
    t_tx();
    conclude();
  end
endmodule
